// ### common/ucf_pkg.sv
/*
 * Constants shared by the serial core: register offsets, field
 * positions, reset values and bit timing.
 * Assumes a 32-bit APB master and one clock, pclk, for bus and baud logic.
 */
package ucf_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_DATA = 8'h00;    // Tx write / rx read
   localparam logic [7:0] OFS_LCR_HI = 8'h04;  // line_control_high_byte
   localparam logic [7:0] OFS_LCR_MID = 8'h08; // line_control_mid_byte
   localparam logic [7:0] OFS_LCR_LO = 8'h0C;  // line_control_low_byte
   localparam logic [7:0] OFS_CTRL = 8'h10;    // serial_mask_control
   localparam logic [7:0] OFS_FLAG = 8'h14;    // Flag readback
   localparam logic [7:0] OFS_IRQ = 8'h18;     // Source read, clear write
   localparam logic [7:0] OFS_RXSTAT = 8'h1C;  // Overrun, write clears
   // High byte of the line control word
   localparam int LCR_BRK = 0;   // Send break; stored and read back, transmitter ignores it
   localparam int LCR_PEN = 1;   // Parity enable
   localparam int LCR_EPS = 2;   // Even parity select
   localparam int LCR_STP2 = 3;  // Two stop bits
   localparam int LCR_FEN = 4;   // FIFO enable
   localparam int LCR_WLO = 5;   // Word length low bit (2 bits)
   localparam int LCR_HI_W = 7;  // Used width of the high byte
   localparam logic [6:0] LCR_HI_RST = 7'h00;
   localparam logic [15:0] DIV_RST = 16'h0000;
   // Control register fields
   localparam int CTL_EN = 0;    // UART enable
   localparam int CTL_MSK = 3;   // Mask bits 6:3 = rt, tx, rx, ms
   localparam int CTL_LBE = 7;   // loopback_enable
   localparam logic [7:0] CTL_RST = 8'h00;
   // Interrupt source order
   localparam int IRQ_MS = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_TX = 2;
   localparam int IRQ_RT = 3;
   // Receive entry layout
   localparam int RXE_BRK = 10;
   localparam int RXE_PE = 9;
   localparam int RXE_FE = 8;
   localparam int RXE_W = 11;
   // Bit timing in baud_tick_x16 pulses
   localparam logic [3:0] TICK_LAST = 4'hF;  // 16th tick of a bit
   localparam logic [3:0] TICK_MID = 4'h7;   // 8th tick, mid bit
   localparam int TIMEOUT_BITS = 32;
   localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_BITS * 16);
   localparam logic [3:0] WL_BASE = 4'h5;    // Word length code 0 = 5 bits
   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
   } ucf_state_t;
endpackage

// ### src/ucf_core.sv
/*
 * Serial transmitter/receiver core with 16-entry FIFOs, divisor baud
 * generator, holding-register mode, loopback and four interrupt sources.
 * Assumes an APB master on pclk; serial and modem pins are asynchronous
 * and are synchronised here. The reference clock is pclk itself.
 */
// Behaviour
// - 23-bit line control over three byte locations
// - 16-bit down counter reloads, pulses x16 tick
// - Bit period is sixteen x16 ticks
// - 16-entry tx and rx FIFOs, rx three flags
// - Transmit starts on write when enabled, runs until empty
// - Busy while FIFO non-empty or shifter active
// - Start bit confirmed low at eighth tick
// - Data sampled every sixteenth tick, parity checked
// - Low stop sample is framing error, store
// - Rx entry: break, parity, framing, data
// - Full FIFO: overrun set, character dropped
// - FIFO disabled acts as one-byte holding
// - Loopback routes tx line into receiver
// - Four sources, masked, raw status readable
// - Modem line change sets irq, write clears
// - FIFO mode rx irq at eight or more
// - Holding mode rx irq while full
// - FIFO mode tx irq at eight free
// - Holding mode tx irq while empty
// - Tx irq ignores UART enable
// - Rx timeout after 32 idle bit periods
// - Combined irq is OR of masked sources
// - Frame: start, data LSB first, parity, stops
// - Asynchronous inputs synchronised before use
module ucf_core
   import ucf_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line and modem status
   input wire logic serial_rx_in,
   output logic serial_tx_out,
   input wire logic clear_to_send_n,
   input wire logic carrier_detect_n,
   input wire logic set_ready_n,
   // Interrupts and status
   output logic modem_status_irq,
   output logic rx_fifo_irq,
   output logic rx_timeout_irq,
   output logic tx_fifo_irq,
   output logic combined_irq,
   output logic busy
);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_HALF = (AW+1)'(DEPTH / 2);
   localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

   // Character parity: even makes the total count of ones even
   function automatic logic par_of(input logic [7:0] d, input logic [1:0] wl,
                                   input logic even);
      logic [7:0] m;
      m = 8'hFF >> (3 - wl);
      par_of = ^(d & m) ^ ~even;
   endfunction

   // FIFO full: holding mode caps the occupancy at one
   function automatic logic is_full(input logic [AW:0] c, input logic fen);
      is_full = fen ? (c == CNT_FULL) : (c >= CNT_ONE);
   endfunction

   // Line control word, control register and sticky flags
   logic [6:0] lcr_hi_ff;       // Framing 7 bits of the 23-bit word
   logic [15:0] div_ff;         // Baud divisor
   logic [7:0] ctrl_ff;         // Enable, masks, loopback
   logic ovr_ff;                // Overrun, tied to no entry
   logic ms_ff;                 // Modem status change latch
   logic [1:0] wlen;
   assign wlen = lcr_hi_ff[LCR_WLO +: 2];

   // APB decode: zero wait states, answer in the access cycle
   logic setup, wr_done, rd_done, addr_ok;
   assign setup = psel & ~penable;
   assign wr_done = psel & penable & pwrite & pready;
   assign rd_done = psel & penable & ~pwrite & pready;
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_RXSTAT);

   // Synchronisers: first stage feeds only the second
   logic [3:0] sync1_ff, sync2_ff;  // rx, cts, dcd, dsr
   logic [2:0] modem_last_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 4'hF;
         sync2_ff <= 4'hF;
         modem_last_ff <= 3'h7;
      end else begin
         // Pins may change at any time relative to pclk
         sync1_ff <= {set_ready_n, carrier_detect_n, clear_to_send_n,
                      serial_rx_in};
         sync2_ff <= sync1_ff;
         modem_last_ff <= sync2_ff[3:1];
      end
   end

   // Baud generator
   logic [15:0] bcnt_ff;
   logic tick_ff;               // baud_tick_x16
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_ff <= DIV_RST;
         tick_ff <= 1'b0;
      end else if (bcnt_ff == 16'h0000) begin
         bcnt_ff <= div_ff;     // Reload and pulse
         tick_ff <= 1'b1;
      end else begin
         bcnt_ff <= bcnt_ff - 16'h0001;
         tick_ff <= 1'b0;
      end
   end

   // FIFO storage and pointers
   logic [7:0] txm_ff [DEPTH];
   logic [RXE_W-1:0] rxm_ff [DEPTH];
   logic [AW-1:0] txw_ff, txr_ff, rxw_ff, rxr_ff;
   logic [AW:0] txc_ff, rxc_ff;
   logic tx_push, tx_pop, rx_push, rx_pop, rx_done;
   logic [RXE_W-1:0] rx_entry;
   assign tx_push = wr_done && paddr == OFS_DATA &&
                    !is_full(txc_ff, lcr_hi_ff[LCR_FEN]);
   assign rx_pop = rd_done && paddr == OFS_DATA && rxc_ff != '0;
   assign rx_push = rx_done && !is_full(rxc_ff, lcr_hi_ff[LCR_FEN]);

   // Transmit FIFO; holding mode only changes the full flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txw_ff <= '0;
         txr_ff <= '0;
         txc_ff <= '0;
      end else begin
         if (tx_push) begin
            txm_ff[txw_ff] <= pwdata[7:0];
            txw_ff <= txw_ff + 1'b1;
         end
         if (tx_pop)
            txr_ff <= txr_ff + 1'b1;
         txc_ff <= txc_ff + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      end
   end

   // Receive FIFO; a full FIFO keeps its contents
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxw_ff <= '0;
         rxr_ff <= '0;
         rxc_ff <= '0;
      end else begin
         if (rx_push) begin
            rxm_ff[rxw_ff] <= rx_entry;
            rxw_ff <= rxw_ff + 1'b1;
         end
         if (rx_pop)
            rxr_ff <= rxr_ff + 1'b1;
         rxc_ff <= rxc_ff + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      end
   end

   // Transmitter
   ucf_state_t tx_st_ff;
   logic [3:0] txt_ff;          // Ticks within the bit
   logic [2:0] txb_ff;          // Data bit index or stop count
   logic [7:0] txd_ff;
   logic txo_ff;                // Internal line, also looped back
   assign tx_pop = tx_st_ff == ST_IDLE && ctrl_ff[CTL_EN] && txc_ff != '0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_ff <= ST_IDLE;
         txt_ff <= 4'h0;
         txb_ff <= 3'h0;
         txd_ff <= 8'h00;
         txo_ff <= 1'b1;
      end else if (tx_pop) begin
         // A written character starts a frame at once
         tx_st_ff <= ST_START;
         txd_ff <= txm_ff[txr_ff];
         txt_ff <= 4'h0;
         txo_ff <= 1'b0;        // Start bit
      end else if (tick_ff && tx_st_ff != ST_IDLE) begin
         txt_ff <= txt_ff + 4'h1;
         if (txt_ff == TICK_LAST) begin
            // One bit lasts sixteen ticks
            case (tx_st_ff)
               ST_START: begin
                  tx_st_ff <= ST_DATA;
                  txb_ff <= 3'h0;
                  txo_ff <= txd_ff[0];   // LSB first
               end
               ST_DATA: begin
                  if (txb_ff == 3'(wlen) + 3'h4) begin
                     tx_st_ff <= lcr_hi_ff[LCR_PEN] ? ST_PAR : ST_STOP;
                     txo_ff <= lcr_hi_ff[LCR_PEN] ?
                        par_of(txd_ff, wlen, lcr_hi_ff[LCR_EPS]) : 1'b1;
                     txb_ff <= 3'h0;
                  end else begin
                     txb_ff <= txb_ff + 3'h1;
                     txo_ff <= txd_ff[txb_ff + 3'h1];
                  end
               end
               ST_PAR: begin
                  tx_st_ff <= ST_STOP;
                  txo_ff <= 1'b1;
               end
               ST_STOP: begin
                  // Second stop bit when selected
                  if (lcr_hi_ff[LCR_STP2] && txb_ff == 3'h0)
                     txb_ff <= 3'h1;
                  else
                     tx_st_ff <= ST_IDLE;
               end
               default: tx_st_ff <= ST_IDLE;
            endcase
         end
      end
   end

   // Receiver; loopback picks the internal transmit line
   ucf_state_t rx_st_ff;
   logic [3:0] rxt_ff;
   logic [2:0] rxb_ff;
   logic [7:0] rxd_ff;
   logic rx_pe_ff, rx_line;
   logic [RXE_W-1:0] rx_entry_ff;
   logic rx_done_ff;
   assign rx_line = ctrl_ff[CTL_LBE] ? txo_ff : sync2_ff[0];
   assign rx_done = rx_done_ff;
   assign rx_entry = rx_entry_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_ff <= ST_IDLE;
         rxt_ff <= 4'h0;
         rxb_ff <= 3'h0;
         rxd_ff <= 8'h00;
         rx_pe_ff <= 1'b0;
         rx_done_ff <= 1'b0;
         rx_entry_ff <= '0;
      end else begin
         rx_done_ff <= 1'b0;
         case (rx_st_ff)
            ST_IDLE: begin
               // Low on a marking line starts the counter
               if (ctrl_ff[CTL_EN] && !rx_line) begin
                  rx_st_ff <= ST_START;
                  rxt_ff <= 4'h0;
                  rxd_ff <= 8'h00;
                  rx_pe_ff <= 1'b0;
               end
            end
            ST_START: if (tick_ff) begin
               rxt_ff <= rxt_ff + 4'h1;
               if (rxt_ff == TICK_MID) begin
                  // Still low at the eighth tick, else false start
                  rx_st_ff <= rx_line ? ST_IDLE : ST_DATA;
                  rxt_ff <= 4'h0;
                  rxb_ff <= 3'h0;
               end
            end
            ST_DATA: if (tick_ff) begin
               rxt_ff <= rxt_ff + 4'h1;
               if (rxt_ff == TICK_LAST) begin
                  // One sample per bit period
                  rxd_ff[rxb_ff] <= rx_line;
                  rxb_ff <= rxb_ff + 3'h1;
                  if (rxb_ff == 3'(wlen) + 3'h4)
                     rx_st_ff <= lcr_hi_ff[LCR_PEN] ? ST_PAR : ST_STOP;
               end
            end
            ST_PAR: if (tick_ff) begin
               rxt_ff <= rxt_ff + 4'h1;
               if (rxt_ff == TICK_LAST) begin
                  rx_pe_ff <= rx_line ^
                     par_of(rxd_ff, wlen, lcr_hi_ff[LCR_EPS]);
                  rx_st_ff <= ST_STOP;
               end
            end
            ST_STOP: if (tick_ff) begin
               rxt_ff <= rxt_ff + 4'h1;
               if (rxt_ff == TICK_LAST) begin
                  // Low stop is a framing error; all-low is break unless odd parity is on
                  rx_entry_ff <= {!rx_line && rxd_ff == 8'h00 && !rx_pe_ff
                                  && !(lcr_hi_ff[LCR_PEN] &&
                                  par_of(8'h00, wlen, lcr_hi_ff[LCR_EPS])),
                                  rx_pe_ff, !rx_line, rxd_ff};
                  rx_done_ff <= 1'b1;
                  rx_st_ff <= ST_IDLE;
               end
            end
            default: rx_st_ff <= ST_IDLE;
         endcase
      end
   end

   // Receive timeout: ticks since the last stored character
   logic [9:0] rto_ff;
   logic rt_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rto_ff <= 10'h000;
         rt_ff <= 1'b0;
      end else if (rxc_ff == '0 || rx_push) begin
         rto_ff <= 10'h000;
         rt_ff <= rx_push ? rt_ff : 1'b0;  // Emptying clears it
      end else if (tick_ff && rto_ff != TIMEOUT_TICKS) begin
         rto_ff <= rto_ff + 10'h001;
         if (rto_ff == TIMEOUT_TICKS - 10'h001)
            rt_ff <= 1'b1;                 // 32 bit periods quiet
      end
   end

   // Register writes; line control is three byte locations
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcr_hi_ff <= LCR_HI_RST;
         div_ff <= DIV_RST;
         ctrl_ff <= CTL_RST;
      end else if (wr_done) begin
         case (paddr)
            OFS_LCR_HI: lcr_hi_ff <= pwdata[LCR_HI_W-1:0];
            OFS_LCR_MID: div_ff[15:8] <= pwdata[7:0];
            OFS_LCR_LO: div_ff[7:0] <= pwdata[7:0];
            OFS_CTRL: ctrl_ff <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Sticky flags; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_ff <= 1'b0;
         ms_ff <= 1'b0;
      end else begin
         if (rx_done && !rx_push)
            ovr_ff <= 1'b1;
         else if (wr_done && paddr == OFS_RXSTAT)
            ovr_ff <= 1'b0;
         if (sync2_ff[3:1] != modem_last_ff)
            ms_ff <= 1'b1;
         else if (wr_done && paddr == OFS_IRQ)
            ms_ff <= 1'b0;
      end
   end

   // Raw interrupt sources; tx ignores the enable bit
   logic [3:0] raw;
   assign raw[IRQ_MS] = ms_ff;
   assign raw[IRQ_RX] = lcr_hi_ff[LCR_FEN] ? (rxc_ff >= CNT_HALF)
                                           : (rxc_ff != '0);
   assign raw[IRQ_TX] = lcr_hi_ff[LCR_FEN] ? (txc_ff <= CNT_HALF)
                                           : (txc_ff == '0);
   assign raw[IRQ_RT] = rt_ff;

   // Registered interrupt and busy outputs
   logic [3:0] irq_ff;
   logic comb_ff, busy_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 4'h0;
         comb_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         irq_ff <= raw & ctrl_ff[CTL_MSK +: 4];
         comb_ff <= |(raw & ctrl_ff[CTL_MSK +: 4]);
         busy_ff <= tx_push || txc_ff != '0 || tx_st_ff != ST_IDLE;
      end
   end

   // Read mux sampled in setup; unmapped addresses give an error
   logic [31:0] rdata_ff;
   logic ready_ff, err_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= 32'h0000_0000;
         ready_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ready_ff <= setup;
         err_ff <= setup && !addr_ok;
         rdata_ff <= 32'h0000_0000;
         if (setup && !pwrite) begin
            case (paddr)
               OFS_DATA: rdata_ff <= 32'(rxm_ff[rxr_ff]);
               OFS_LCR_HI: rdata_ff <= 32'(lcr_hi_ff);
               OFS_LCR_MID: rdata_ff <= 32'(div_ff[15:8]);
               OFS_LCR_LO: rdata_ff <= 32'(div_ff[7:0]);
               OFS_CTRL: rdata_ff <= 32'(ctrl_ff);
               OFS_FLAG: rdata_ff <= 32'({busy_ff,
                  is_full(rxc_ff, lcr_hi_ff[LCR_FEN]), txc_ff == '0,
                  rxc_ff == '0, is_full(txc_ff, lcr_hi_ff[LCR_FEN])});
               OFS_IRQ: rdata_ff <= 32'(raw);
               OFS_RXSTAT: rdata_ff <= 32'(ovr_ff);
               default: rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign prdata = rdata_ff;
   assign pready = ready_ff;
   assign pslverr = err_ff;
   assign serial_tx_out = txo_ff;
   assign modem_status_irq = irq_ff[IRQ_MS];
   assign rx_fifo_irq = irq_ff[IRQ_RX];
   assign tx_fifo_irq = irq_ff[IRQ_TX];
   assign rx_timeout_irq = irq_ff[IRQ_RT];
   assign combined_irq = comb_ff;
   assign busy = busy_ff;

   // Checks
   a_tick_reload: assert property (@(posedge pclk) disable iff (!presetn)
      tick_ff |-> bcnt_ff == $past(div_ff))
      else $error("baud counter not reloaded with tick");
   a_start_false: assert property (@(posedge pclk) disable iff (!presetn)
      rx_st_ff == ST_START && tick_ff && rxt_ff == TICK_MID && rx_line
      |=> rx_st_ff == ST_IDLE)
      else $error("false start bit not ignored");
   a_ovr_set: assert property (@(posedge pclk) disable iff (!presetn)
      rx_done && is_full(rxc_ff, lcr_hi_ff[LCR_FEN])
      |=> ovr_ff && $stable(rxw_ff))
      else $error("overrun not flagged or FIFO changed");
   a_hold_cap: assert property (@(posedge pclk) disable iff (!presetn)
      !lcr_hi_ff[LCR_FEN] |-> rxc_ff <= CNT_ONE)
      else $error("holding mode stored more than one");
   a_busy_hold: assert property (@(posedge pclk) disable iff (!presetn)
      tx_st_ff == ST_STOP |=> busy)
      else $error("busy dropped during stop bit");
   a_ms_change: assert property (@(posedge pclk) disable iff (!presetn)
      sync2_ff[3:1] != modem_last_ff |=> ms_ff)
      else $error("modem change missed");
   a_rx_level: assert property (@(posedge pclk) disable iff (!presetn)
      lcr_hi_ff[LCR_FEN] && ctrl_ff[CTL_MSK+IRQ_RX] && rxc_ff >= CNT_HALF
      && $stable(rxc_ff) |=> rx_fifo_irq)
      else $error("rx irq missing at half full");
   a_comb_or: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 combined_irq == |irq_ff)
      else $error("combined irq differs from sources");
   a_loop_path: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_ff[CTL_LBE] |-> rx_line == serial_tx_out)
      else $error("loopback path broken");
   a_start_low: assert property (@(posedge pclk) disable iff (!presetn)
      tx_pop |=> !serial_tx_out ##0 tx_st_ff == ST_START)
      else $error("frame did not begin with start bit");
endmodule

// ### sim/ucf_peer.sv
/* Serial peer model for the far side of the core's line pins.
 * Assumes 8 data bits, no parity, one stop bit, fixed bit period. */
module ucf_peer #(
   parameter int BIT_CYC = 32 // Bit period in pclk cycles
) (
   // Clock
   input wire logic pclk,
   // Serial lines
   input wire logic serial_tx_out,
   output logic serial_rx_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx_q[$]; // Bytes decoded from the core
   logic [7:0] sh; // Decoder shift value
   initial serial_rx_in = 1'b1; // Marking level while idle
   // Decoder samples mid bit, so a start bit short by a tick is fine
   always begin
      @(negedge serial_tx_out);
      repeat (BIT_CYC / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge pclk);
         sh[i] = serial_tx_out; // LSB first
      end
      repeat (BIT_CYC) @(posedge pclk);
      rx_q.push_back(sh);
   end
   // Sends start, data LSB first, one stop of the given level
   task automatic send(input logic [7:0] d, input logic stp);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge pclk);
         serial_rx_in <= f[i];
         repeat (BIT_CYC - 1) @(posedge pclk);
      end
      @(posedge pclk);
      serial_rx_in <= 1'b1;
      repeat (BIT_CYC) @(posedge pclk);
   endtask
endmodule

// ### sim/tb.sv
/* Self-checking bench for the serial core: APB master, queue model.
 * Assumes divisor 1, so one bit lasts 32 pclk cycles. */
module tb;
   import ucf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, serr, rxd, txd, cts_n = 1, dcd_n = 1, dsr_n = 1;
   logic ms_irq, rx_irq, rt_irq, tx_irq, all_irq, busy;
   logic [7:0] tx_q[$], b; // Expected transmit bytes
   int err_count = 0, n_tests = 0, seed = 57;
   always #2 pclk = ~pclk;
   ucf_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_rx_in(rxd), .serial_tx_out(txd), .clear_to_send_n(cts_n),
      .carrier_detect_n(dcd_n), .set_ready_n(dsr_n),
      .modem_status_irq(ms_irq), .rx_fifo_irq(rx_irq),
      .rx_timeout_irq(rt_irq), .tx_fifo_irq(tx_irq),
      .combined_irq(all_irq), .busy(busy));
   ucf_peer #(.BIT_CYC(32)) peer (.pclk(pclk), .serial_tx_out(txd),
      .serial_rx_in(rxd));
   // Single compare for every kind of result
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic complete_run;
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // APB transfer; waits for pready, bounded so a hang ends the run
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         err_count++;
         complete_run();
      end
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Waits until the transmitter has gone idle
   task automatic wait_idle;
      int n;
      for (n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge pclk);
      if (n == 4000) begin
         err_count++;
         complete_run();
      end
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, OFS_CTRL, 0);
      chk(r, 32'h0);
      apb(0, OFS_FLAG, 0);
      chk(r, 32'h6);
      apb(0, 8'h20, 0);
      chk(serr, 1); // Unmapped place is refused
      apb(1, OFS_LCR_LO, 32'h1);
      apb(1, OFS_LCR_MID, 32'h0);
      apb(1, OFS_LCR_HI, 32'h70);
      apb(1, OFS_CTRL, 32'h20); // Tx mask only, core still disabled
      @(posedge pclk); // Interrupt outputs follow the mask one edge later
      chk(tx_irq, 1);
      chk(all_irq, 1);
      apb(1, OFS_CTRL, 32'h79);
      // Three back-to-back characters, random values
      for (int i = 0; i < 3; i++) begin
         b = 8'($random(seed));
         tx_q.push_back(b);
         apb(1, OFS_DATA, {24'h0, b});
      end
      chk(busy, 1);
      wait_idle();
      repeat (40) @(posedge pclk);
      chk(peer.rx_q.size(), tx_q.size());
      foreach (tx_q[i]) chk(peer.rx_q[i], tx_q[i]);
      // Received characters, the last one with its stop bit low
      for (int i = 0; i < 3; i++) begin
         b = 8'($random(seed)) | 8'h01;
         peer.send(b, i != 2);
         apb(0, OFS_DATA, 0);
         chk(r, {21'h0, 2'b00, i == 2, b});
      end
      // Eight characters reach the half-full receive level
      for (int i = 0; i < 8; i++) peer.send(8'(i + 1), 1'b1);
      chk(rx_irq, 1);
      for (int i = 0; i < 8; i++) begin
         apb(0, OFS_DATA, 0);
         chk(r, i + 1);
      end
      @(posedge pclk);
      chk(rx_irq, 0);
      cts_n <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(ms_irq, 1);
      apb(1, OFS_IRQ, 0);
      apb(0, OFS_IRQ, 0);
      chk(r[IRQ_MS], 0);
      // Holding mode: second character overruns the first
      apb(1, OFS_LCR_HI, 32'h60);
      peer.send(8'h5A, 1'b1);
      chk(rx_irq, 1);
      peer.send(8'hC3, 1'b1);
      apb(0, OFS_RXSTAT, 0);
      chk(r[0], 1);
      // Held character stays unread well past 32 bit periods
      repeat (1100) @(posedge pclk);
      chk(rt_irq, 1);
      apb(0, OFS_DATA, 0);
      chk(r, 32'h5A);
      repeat (2) @(posedge pclk);
      chk(rt_irq, 0);
      chk(rx_irq, 0);
      apb(1, OFS_CTRL, 32'hF9);
      apb(1, OFS_DATA, 32'hA5);
      wait_idle();
      chk(tx_irq, 1);
      repeat (40) @(posedge pclk);
      apb(0, OFS_DATA, 0);
      chk(r, 32'hA5);
      complete_run();
   end
endmodule
